// file: psc_cache.sv
// Top of the primary split cache arrays: instruction and data caches.
//
// The implementer's own choices: the address-and-strobe port.
`default_nettype none
module psc_cache
    import psc_pkg::*;
(
    input  wire logic                       sys_clk,
    input  wire logic                       rst_n,
    // Instruction fetch lookup.
    input  wire logic                       if_req,
    input  wire logic [31:0]                if_vaddr,
    input  wire logic [psc_pkg::PHYSICAL_TAG_FIELD_W-1:0] if_physical_tag_field,
    output logic                            if_valid,
    output logic                            if_hit,
    output logic [31:0]                     if_rdata,
    // Instruction line fill.
    input  wire logic                       if_fill_we,
    input  wire logic [31:0]                if_fill_addr,
    input  wire logic [31:0]                if_fill_data,
    input  wire logic                       if_fill_tag_we,
    input  wire logic                       if_inval,
    // Data load or store lookup.
    input  wire logic                       dc_req,
    input  wire logic                       dc_we,
    input  wire logic [31:0]                dc_vaddr,
    input  wire logic [psc_pkg::PHYSICAL_TAG_FIELD_W-1:0] dc_physical_tag_field,
    input  wire logic [31:0]                dc_wdata,
    output logic                            dc_valid,
    output logic                            dc_hit,
    output logic [31:0]                     dc_rdata,
    output logic                            dc_victim_dirty,
    output logic [psc_pkg::PHYSICAL_TAG_FIELD_W-1:0]      dc_victim_physical_tag_field,
    // Data fill and maintenance.
    input  wire logic                       dc_fill_we,
    input  wire logic [31:0]                dc_fill_addr,
    input  wire logic [31:0]                dc_fill_data,
    input  wire psc_pkg::psc_dop_type       dc_op,
    input  wire logic [31:0]                dc_op_addr,
    output logic                            dc_wb_req,
    output logic [psc_pkg::PHYSICAL_TAG_FIELD_W-1:0]      dc_wb_physical_tag_field
);
    import psc_pkg::*;

    logic [IIDX_W-1:0]   if_idx;
    logic [IWADDR_W-1:0] if_waddr;
    logic [IWADDR_W-1:0] if_fill_waddr;
    psc_itag_type        if_tag_rd;
    psc_itag_type        if_tag_wr;
    logic                if_tag_we;
    logic [PHYSICAL_TAG_FIELD_W-1:0]   if_physical_tag_field_q;
    logic                if_req_q;
    logic                next_if_req_q;
    logic [PHYSICAL_TAG_FIELD_W-1:0]   next_if_physical_tag_field_q;

    logic [DIDX_W-1:0]   dc_idx;
    logic [DWADDR_W-1:0] dc_waddr;
    psc_dtag_type        dc_tag_rd;
    psc_dtag_type        dc_tag_wr;
    logic                dc_tag_we;
    logic [DIDX_W-1:0]   dc_tag_widx;
    logic [DIDX_W-1:0]   dc_tag_ridx;
    logic                dc_data_we;
    logic [DWADDR_W-1:0] dc_data_waddr;
    logic [31:0]         dc_data_wdata;

    // Stage one registers of the data pipeline: request, tag and address.
    logic                s1_req;
    logic                s1_we;
    logic [PHYSICAL_TAG_FIELD_W-1:0]   s1_physical_tag_field;
    logic [DWADDR_W-1:0] s1_waddr;
    logic [31:0]         s1_wdata;
    logic                next_s1_req;
    logic                next_s1_we;
    logic [PHYSICAL_TAG_FIELD_W-1:0]   next_s1_physical_tag_field;
    logic [DWADDR_W-1:0] next_s1_waddr;
    logic [31:0]         next_s1_wdata;
    logic                s1_hit;
    logic                s1_op;
    logic                next_s1_op;
    psc_dop_type         s1_opk;
    psc_dop_type         next_s1_opk;
    logic                next_dc_wb_req;
    logic [PHYSICAL_TAG_FIELD_W-1:0]   next_dc_wb_physical_tag_field;

    // Virtual index selects exactly one candidate line in each cache.
    assign if_idx        = if_vaddr[IIDX_MSB:IIDX_LSB];
    assign if_waddr      = if_vaddr[IIDX_MSB:IWSEL_LSB];
    assign if_fill_waddr = if_fill_addr[IIDX_MSB:IWSEL_LSB];
    assign dc_idx        = dc_vaddr[DIDX_MSB:DIDX_LSB];
    assign dc_waddr      = dc_vaddr[DIDX_MSB:DWSEL_LSB];

    // Instruction tag write: fill sets valid, invalidate clears it.
    always_comb
    begin
        if_tag_we       = if_fill_tag_we || if_inval;
        if_tag_wr.valid = if_fill_tag_we && !if_inval;
        if_tag_wr.physical_tag_field  = if_fill_addr[PHYSICAL_TAG_FIELD_MSB:PHYSICAL_TAG_FIELD_LSB];
    end

    psc_tagarr #(
        .LINES (ILINES),
        .IW    (IIDX_W),
        .TW    (ITAG_W)
    ) u_itag (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .rd_idx  (if_idx),
        .rd_tag  (if_tag_rd),
        .wr_en   (if_tag_we),
        .wr_idx  (if_fill_addr[IIDX_MSB:IIDX_LSB]),
        .wr_tag  (if_tag_wr)
    );

    psc_ram #(
        .DEPTH (IWORDS),
        .AW    (IWADDR_W),
        .DW    (WORD_W)
    ) u_idata (
        .sys_clk (sys_clk),
        .rd_addr (if_waddr),
        .rd_data (if_rdata),
        .wr_en   (if_fill_we),
        .wr_addr (if_fill_waddr),
        .wr_data (if_fill_data)
    );

    // Fetch request and translated tag ride beside the array read.
    always_comb
    begin
        next_if_req_q  = if_req;
        next_if_physical_tag_field_q = if_physical_tag_field;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            if_req_q  <= 1'b0;
            if_physical_tag_field_q <= '0;
        end
        else
        begin
            if_req_q  <= next_if_req_q;
            if_physical_tag_field_q <= next_if_physical_tag_field_q;
        end
    end

    // Instruction result one clock after the request.
    assign if_valid = if_req_q;
    assign if_hit   = if_req_q && if_tag_rd.valid && (if_tag_rd.physical_tag_field == if_physical_tag_field_q);

    // Maintenance ops and fills use their own index, lookups use the load index.
    assign dc_tag_ridx = (dc_op != PSC_DOP_NONE) ? dc_op_addr[DIDX_MSB:DIDX_LSB] : dc_idx;

    psc_tagarr #(
        .LINES (DLINES),
        .IW    (DIDX_W),
        .TW    (DTAG_W)
    ) u_dtag (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .rd_idx  (dc_tag_ridx),
        .rd_tag  (dc_tag_rd),
        .wr_en   (dc_tag_we),
        .wr_idx  (dc_tag_widx),
        .wr_tag  (dc_tag_wr)
    );

    psc_ram #(
        .DEPTH (DWORDS),
        .AW    (DWADDR_W),
        .DW    (WORD_W)
    ) u_ddata (
        .sys_clk (sys_clk),
        .rd_addr (dc_waddr),
        .rd_data (dc_rdata),
        .wr_en   (dc_data_we),
        .wr_addr (dc_data_waddr),
        .wr_data (dc_data_wdata)
    );

    // Stage one captures the request while the tag is read; commands bring their own line.
    always_comb
    begin
        next_s1_req   = dc_req && (dc_op == PSC_DOP_NONE);
        next_s1_we    = dc_req && dc_we && (dc_op == PSC_DOP_NONE);
        next_s1_physical_tag_field  = dc_physical_tag_field;
        next_s1_waddr = (dc_op != PSC_DOP_NONE) ? dc_op_addr[DIDX_MSB:DWSEL_LSB] : dc_waddr;
        next_s1_wdata = dc_wdata;
        next_s1_op    = (dc_op == PSC_DOP_WBINV) || (dc_op == PSC_DOP_INV);
        next_s1_opk   = dc_op;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_req   <= 1'b0;
            s1_we    <= 1'b0;
            s1_physical_tag_field  <= '0;
            s1_waddr <= '0;
            s1_wdata <= '0;
            s1_op    <= 1'b0;
            s1_opk   <= PSC_DOP_NONE;
        end
        else
        begin
            s1_req   <= next_s1_req;
            s1_we    <= next_s1_we;
            s1_physical_tag_field  <= next_s1_physical_tag_field;
            s1_waddr <= next_s1_waddr;
            s1_wdata <= next_s1_wdata;
            s1_op    <= next_s1_op;
            s1_opk   <= next_s1_opk;
        end
    end

    // Tag check of stage one: valid and equal physical tag.
    assign s1_hit   = s1_req && dc_tag_rd.valid && (dc_tag_rd.physical_tag_field == s1_physical_tag_field);
    assign dc_valid = s1_req;
    assign dc_hit   = s1_hit;
    assign dc_victim_dirty = s1_req && !s1_hit && dc_tag_rd.valid && dc_tag_rd.dirty;
    assign dc_victim_physical_tag_field  = dc_tag_rd.physical_tag_field;

    // Second stage writes store data on a hit; fills write the array directly.
    always_comb
    begin
        dc_data_we    = (s1_we && s1_hit) || dc_fill_we;
        dc_data_waddr = dc_fill_we ? dc_fill_addr[DIDX_MSB:DWSEL_LSB] : s1_waddr;
        dc_data_wdata = dc_fill_we ? dc_fill_data : s1_wdata;
    end

    // Tag updates: fill validates clean, store hit marks dirty, ops invalidate.
    always_comb
    begin
        dc_tag_we   = 1'b0;
        dc_tag_widx = s1_waddr[DWADDR_W-1:DWSEL_W];
        dc_tag_wr   = dc_tag_rd;
        if (dc_op == PSC_DOP_FILL)
        begin
            dc_tag_we       = 1'b1;
            dc_tag_widx     = dc_op_addr[DIDX_MSB:DIDX_LSB];
            dc_tag_wr.valid = 1'b1;
            dc_tag_wr.dirty = 1'b0;
            dc_tag_wr.physical_tag_field  = dc_op_addr[PHYSICAL_TAG_FIELD_MSB:PHYSICAL_TAG_FIELD_LSB];
        end
        else if (s1_op)
        begin
            dc_tag_we       = 1'b1;
            dc_tag_widx     = s1_waddr[DWADDR_W-1:DWSEL_W];
            dc_tag_wr.valid = 1'b0;
            dc_tag_wr.dirty = 1'b0;
        end
        else if (s1_we && s1_hit)
        begin
            dc_tag_we       = 1'b1;
            dc_tag_wr.dirty = 1'b1;
        end
    end

    // Write-back request only from a maintenance op on a dirty valid line.
    always_comb
    begin
        next_dc_wb_req  = s1_op && (s1_opk == PSC_DOP_WBINV)
                          && dc_tag_rd.valid && dc_tag_rd.dirty;
        next_dc_wb_physical_tag_field = dc_tag_rd.physical_tag_field;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dc_wb_req  <= 1'b0;
            dc_wb_physical_tag_field <= '0;
        end
        else
        begin
            dc_wb_req  <= next_dc_wb_req;
            dc_wb_physical_tag_field <= next_dc_wb_physical_tag_field;
        end
    end

    // A store request as stage one takes it, followed by its tag hit.
    sequence s_store_hit;
        dc_req && dc_we && dc_op == PSC_DOP_NONE && !dc_fill_we ##1 dc_hit;
    endsequence

    a_ihit_needs_valid: assert property (@(posedge sys_clk) disable iff (!rst_n)
        if_hit |-> if_tag_rd.valid && $past(if_req))
        else $error("instruction hit without valid line");

    a_dc_read_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dc_req && dc_op == PSC_DOP_NONE |=> dc_valid)
        else $error("data read not answered in one clock");

    a_if_read_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
        if_req |=> if_valid)
        else $error("instruction read not answered in one clock");

    a_store_two_stage: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_store_hit |-> dc_data_we)
        else $error("store hit not written in stage two");

    a_store_dirty: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s1_we && s1_hit && !s1_op && dc_op != PSC_DOP_FILL |-> dc_tag_we && dc_tag_wr.dirty)
        else $error("store hit did not mark line dirty");

    a_wb_then_inval: assert property (@(posedge sys_clk) disable iff (!rst_n)
        next_dc_wb_req && dc_op != PSC_DOP_FILL |-> dc_tag_we && !dc_tag_wr.valid)
        else $error("written-back line not invalidated");

    a_wb_only_dirty: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dc_wb_req |-> $past(s1_op) && $past(dc_tag_rd.dirty))
        else $error("write-back of a clean line");

    a_dhit_tag_eq: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dc_hit |-> dc_tag_rd.physical_tag_field == s1_physical_tag_field && $past(dc_physical_tag_field) == s1_physical_tag_field)
        else $error("data hit with unequal tag");
endmodule // psc_cache
`default_nettype wire

// file: psc_cache_tb.sv
// Self-checking testbench for the primary split cache arrays.
`default_nettype none
module psc_cache_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import psc_pkg::*;

    logic              sys_clk, rst_n;
    logic              if_req, if_fill_we, if_fill_tag_we, if_inval;
    logic [31:0]       if_vaddr, if_fill_addr, if_fill_data, if_rdata;
    logic [PHYSICAL_TAG_FIELD_W-1:0] if_physical_tag_field, dc_physical_tag_field, dc_victim_physical_tag_field, dc_wb_physical_tag_field, wb_last;
    logic              if_valid, if_hit, dc_req, dc_we, dc_valid, dc_hit;
    logic              dc_victim_dirty, dc_fill_we, dc_wb_req;
    logic [31:0]       dc_vaddr, dc_wdata, dc_rdata, dc_fill_addr, dc_fill_data;
    logic [31:0]       dc_op_addr, wb_count;
    psc_dop_type       dc_op;
    int                n_fail, total_checks;

    psc_cache psc_cache_inst (.sys_clk(sys_clk), .rst_n(rst_n), .if_req(if_req),
        .if_vaddr(if_vaddr), .if_physical_tag_field(if_physical_tag_field), .if_valid(if_valid), .if_hit(if_hit),
        .if_rdata(if_rdata), .if_fill_we(if_fill_we), .if_fill_addr(if_fill_addr),
        .if_fill_data(if_fill_data), .if_fill_tag_we(if_fill_tag_we), .if_inval(if_inval),
        .dc_req(dc_req), .dc_we(dc_we), .dc_vaddr(dc_vaddr), .dc_physical_tag_field(dc_physical_tag_field),
        .dc_wdata(dc_wdata), .dc_valid(dc_valid), .dc_hit(dc_hit), .dc_rdata(dc_rdata),
        .dc_victim_dirty(dc_victim_dirty), .dc_victim_physical_tag_field(dc_victim_physical_tag_field),
        .dc_fill_we(dc_fill_we), .dc_fill_addr(dc_fill_addr), .dc_fill_data(dc_fill_data),
        .dc_op(dc_op), .dc_op_addr(dc_op_addr), .dc_wb_req(dc_wb_req),
        .dc_wb_physical_tag_field(dc_wb_physical_tag_field));

    psc_pipe_model psc_pipe_model_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .wb_req(dc_wb_req), .wb_physical_tag_field(dc_wb_physical_tag_field), .wb_count(wb_count), .wb_last(wb_last));

    // Free-running pipeline clock of 40 ns.
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Counts a comparison and reports it when it does not hold.
    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t %s", $time, m);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Writes eight words of an instruction line, then its tag.
    task automatic i_fill_line(input logic [31:0] pa);
        for (int k = 0; k < 8; k++)
        begin
            @(posedge sys_clk);
            if_fill_we   <= 1'b1;
            if_fill_addr <= pa + 32'(4 * k);
            if_fill_data <= ~(pa + 32'(4 * k));
        end
        @(posedge sys_clk);
        if_fill_we     <= 1'b0;
        if_fill_tag_we <= 1'b1;
        if_fill_addr   <= pa;
        @(posedge sys_clk);
        if_fill_tag_we <= 1'b0;
    endtask

    // One fetch lookup; a hit must return the word stored for that address.
    task automatic i_look(input logic [31:0] va, input logic [PHYSICAL_TAG_FIELD_W-1:0] pt,
                          input logic eh);
        @(posedge sys_clk);
        if_req   <= 1'b1;
        if_vaddr <= va;
        if_physical_tag_field  <= pt;
        @(posedge sys_clk);
        if_req <= 1'b0;
        #1;
        chk(if_valid === 1'b1, "fetch answer missing");
        chk(if_hit === eh, "fetch hit wrong");
        if (eh)
            chk(if_rdata === ~{pt, va[11:0]}, "fetch data wrong");
    endtask

    // Writes four words of a data line, then sets its tag with the fill command.
    task automatic d_fill_line(input logic [31:0] pa);
        for (int k = 0; k < 4; k++)
        begin
            @(posedge sys_clk);
            dc_fill_we   <= 1'b1;
            dc_fill_addr <= pa + 32'(4 * k);
            dc_fill_data <= ~(pa + 32'(4 * k));
        end
        @(posedge sys_clk);
        dc_fill_we <= 1'b0;
        dc_op      <= PSC_DOP_FILL;
        dc_op_addr <= pa;
        dc_vaddr   <= pa;
        @(posedge sys_clk);
        dc_op <= PSC_DOP_NONE;
    endtask

    // Presents one data request for one cycle.
    task automatic d_drive(input logic we, input logic [31:0] va,
                           input logic [PHYSICAL_TAG_FIELD_W-1:0] pt, input logic [31:0] wd);
        @(posedge sys_clk);
        dc_req   <= 1'b1;
        dc_we    <= we;
        dc_vaddr <= va;
        dc_physical_tag_field  <= pt;
        dc_wdata <= wd;
    endtask

    // One load; a hit returns data, a miss reports the indexed victim line.
    task automatic d_look(input logic [31:0] va, input logic [PHYSICAL_TAG_FIELD_W-1:0] pt,
                          input logic eh, input logic [31:0] ed,
                          input logic vd, input logic [PHYSICAL_TAG_FIELD_W-1:0] vp);
        d_drive(1'b0, va, pt, 32'h0000_0000);
        @(posedge sys_clk);
        dc_req <= 1'b0;
        #1;
        chk(dc_valid === 1'b1, "load answer missing");
        chk(dc_hit === eh, "load hit wrong");
        if (eh)
            chk(dc_rdata === ed, "load data wrong");
        else
            chk(dc_victim_dirty === vd, "victim dirty wrong");
        if (!eh && vd)
            chk(dc_victim_physical_tag_field === vp, "victim tag wrong");
    endtask

    // Runs a maintenance command and checks whether a write-back follows.
    task automatic d_op(input psc_dop_type op, input logic [31:0] va,
                        input logic ew, input logic [PHYSICAL_TAG_FIELD_W-1:0] ep);
        logic [31:0] prev;
        prev = wb_count;
        @(posedge sys_clk);
        dc_op      <= op;
        dc_op_addr <= va;
        dc_vaddr   <= va;
        @(posedge sys_clk);
        dc_op <= PSC_DOP_NONE;
        @(posedge sys_clk);
        #1;
        chk(dc_wb_req === ew, "write-back request wrong");
        if (ew)
            chk(dc_wb_physical_tag_field === ep, "write-back tag wrong");
        @(posedge sys_clk);
        #1;
        chk(wb_count === prev + 32'(ew), "write-back count wrong");
        if (ew)
            chk(wb_last === ep, "pipeline saw wrong write-back tag");
    endtask

    // Instruction cache: full line, top and bottom index, alias, tag and valid.
    task automatic t_icache();
        i_fill_line(32'h1234_BFE0);
        i_fill_line(32'h5555_4000);
        for (int k = 0; k < 8; k++)
            i_look(32'h1234_BFE0 + 32'(4 * k), 20'h1234B, 1'b1);
        i_look(32'h5555_401C, 20'h55554, 1'b1);
        i_look(32'h7777_FFE4, 20'h1234B, 1'b1);
        i_look(32'h1234_BFE0, 20'h1234C, 1'b0);
        i_look(32'h1234_BFC0, 20'h1234B, 1'b0);
        @(posedge sys_clk);
        if_inval     <= 1'b1;
        if_fill_addr <= 32'h1234_BFE0;
        @(posedge sys_clk);
        if_inval <= 1'b0;
        i_look(32'h1234_BFE4, 20'h1234B, 1'b0);
    endtask

    // Data cache: loads, pipelined stores, store miss, dirty victim, commands.
    task automatic t_dcache();
        d_fill_line(32'hABCD_1FF0);
        for (int k = 0; k < 4; k++)
            d_look(32'hABCD_1FF0 + 32'(4 * k), 20'hABCD1, 1'b1,
                   ~(32'hABCD_1FF0 + 32'(4 * k)), 1'b0, 20'h00000);
        d_drive(1'b1, 32'hABCD_1FF0, 20'hABCD1, 32'h1111_1111);
        d_drive(1'b1, 32'hABCD_1FF4, 20'hABCD1, 32'h2222_2222);
        d_drive(1'b1, 32'hABCD_1FF8, 20'hABCD2, 32'h3333_3333);
        d_look(32'hABCD_1FF0, 20'hABCD1, 1'b1, 32'h1111_1111, 1'b0, 20'h00000);
        d_look(32'hABCD_1FF4, 20'hABCD1, 1'b1, 32'h2222_2222, 1'b0, 20'h00000);
        d_look(32'hABCD_1FF8, 20'hABCD1, 1'b1, ~32'hABCD_1FF8, 1'b0, 20'h00000);
        d_look(32'hABCD_1FF0, 20'hABCD2, 1'b0, 32'h0, 1'b1, 20'hABCD1);
        d_op(PSC_DOP_WBINV, 32'hABCD_1FF0, 1'b1, 20'hABCD1);
        d_look(32'hABCD_1FF0, 20'hABCD1, 1'b0, 32'h0, 1'b0, 20'h00000);
        d_fill_line(32'h0000_E000);
        d_op(PSC_DOP_WBINV, 32'h0000_E000, 1'b0, 20'h00000);
        d_fill_line(32'h0000_E000);
        d_op(PSC_DOP_INV, 32'h0000_E000, 1'b0, 20'h00000);
        d_look(32'h0000_E000, 20'h0000E, 1'b0, 32'h0, 1'b0, 20'h00000);
    endtask

    // Watchdog that cuts a hang short.
    initial
    begin
        #120000;
        n_fail++;
        results();
    end

    // Reset, then the scenarios, then the verdict.
    initial
    begin
        {rst_n, if_req, if_fill_we, if_fill_tag_we, if_inval} = '0;
        {if_vaddr, if_fill_addr, if_fill_data, if_physical_tag_field, dc_physical_tag_field} = '0;
        {dc_req, dc_we, dc_vaddr, dc_wdata, dc_fill_we} = '0;
        {dc_fill_addr, dc_fill_data, dc_op_addr} = '0;
        dc_op        = PSC_DOP_NONE;
        n_fail       = 0;
        total_checks = 0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_icache();
        t_dcache();
        results();
    end
endmodule // psc_cache_tb
`default_nettype wire

// file: psc_pipe_model.sv
// Pipeline-side model that collects data cache write-back requests.
`default_nettype none
module psc_pipe_model
    import psc_pkg::*;
(
    input  wire logic                       sys_clk,
    input  wire logic                       rst_n,
    input  wire logic                       wb_req,
    input  wire logic [psc_pkg::PHYSICAL_TAG_FIELD_W-1:0] wb_physical_tag_field,
    output logic      [31:0]                wb_count,
    output logic      [psc_pkg::PHYSICAL_TAG_FIELD_W-1:0] wb_last
);
    timeunit 1ns;
    timeprecision 100ps;

    // Counts each write-back pulse and keeps the tag it carried.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wb_count <= 32'h0000_0000;
            wb_last  <= '0;
        end
        else if (wb_req)
        begin
            wb_count <= wb_count + 32'h0000_0001;
            wb_last  <= wb_physical_tag_field;
        end
    end
endmodule // psc_pipe_model
`default_nettype wire

// file: psc_pkg.sv
// Package with constants and carrier types for the primary split cache arrays.
// Behaviour
// - Instruction cache holds 16 KB, data cache holds 8 KB, both on chip.
// - Instruction line is eight words; data line is four words; one tag each.
// - Instruction tag is 21 bits: 20-bit physical tag plus valid.
// - Data tag is 22 bits: 20-bit physical tag, valid and dirty.
// - Both caches direct-mapped and indexed by virtual address bits.
// - Hit decided by comparing stored tag with translated physical address.
// - Stored physical tag field holds physical address bits 31 to 12.
// - Data cache is write-back; stores stay in the line.
// - Reads of either cache complete in one pipeline clock.
// - Data cache writes are pipelined, one completing per clock.
// - Write stage one checks tag, stage two writes the data array.
// - Data cache line index is virtual address bits 12 to 4.
// - Instruction cache line index is virtual address bits 13 to 5.
// - Dirty line leaves only on miss replacement or write-back operation; PSC_DOP_INV also drops a dirty line without write-back.
// - A written-back line is set invalid; a PSC_DOP_FILL the next cycle takes the tag write instead.
`default_nettype none
package psc_pkg;
    localparam int ICACHE_BYTES    = 16384;
    localparam int DCACHE_BYTES    = 8192;
    localparam int ILINE_WORDS     = 8;
    localparam int DLINE_WORDS     = 4;
    localparam int WORD_W          = 32;
    localparam int PHYSICAL_TAG_FIELD_W          = 20;
    localparam int PHYSICAL_TAG_FIELD_LSB        = 12;
    localparam int PHYSICAL_TAG_FIELD_MSB        = 31;
    localparam int ITAG_W          = 21;
    localparam int DTAG_W          = 22;
    localparam int IIDX_LSB        = 5;
    localparam int IIDX_MSB        = 13;
    localparam int DIDX_LSB        = 4;
    localparam int DIDX_MSB        = 12;
    localparam int IWSEL_LSB       = 2;
    localparam int IWSEL_MSB       = 4;
    localparam int DWSEL_LSB       = 2;
    localparam int DWSEL_MSB       = 3;
    localparam int ILINES          = ICACHE_BYTES / (ILINE_WORDS * 4);
    localparam int DLINES          = DCACHE_BYTES / (DLINE_WORDS * 4);
    localparam int IIDX_W          = IIDX_MSB - IIDX_LSB + 1;
    localparam int DIDX_W          = DIDX_MSB - DIDX_LSB + 1;
    localparam int IWSEL_W         = IWSEL_MSB - IWSEL_LSB + 1;
    localparam int DWSEL_W         = DWSEL_MSB - DWSEL_LSB + 1;
    localparam int IWORDS          = ICACHE_BYTES / 4;
    localparam int DWORDS          = DCACHE_BYTES / 4;
    localparam int IWADDR_W        = IIDX_W + IWSEL_W;
    localparam int DWADDR_W        = DIDX_W + DWSEL_W;

    // Instruction tag entry: valid plus physical tag.
    typedef struct packed {
        logic              valid;
        logic [PHYSICAL_TAG_FIELD_W-1:0] physical_tag_field;
    } psc_itag_type;

    // Data tag entry: valid, dirty plus physical tag.
    typedef struct packed {
        logic              valid;
        logic              dirty;
        logic [PHYSICAL_TAG_FIELD_W-1:0] physical_tag_field;
    } psc_dtag_type;

    // Data cache tag maintenance commands.
    typedef enum logic [1:0] {
        PSC_DOP_NONE,
        PSC_DOP_FILL,
        PSC_DOP_WBINV,
        PSC_DOP_INV
    } psc_dop_type;
endpackage
`default_nettype wire

// file: psc_ram.sv
// Single-port-write, registered-read word memory used for cache arrays.
`default_nettype none
module psc_ram #(
    parameter int DEPTH  = 256,
    parameter int AW     = 8,
    parameter int DW     = 32
) (
    input  wire logic          sys_clk,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data
);
    logic [DW-1:0] mem [DEPTH];

    // Write port and registered read port; read returns data a cycle later.
    always_ff @(posedge sys_clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // psc_ram
`default_nettype wire

// file: psc_tagarr.sv
// Tag array with a valid bit per line that clears under reset.
`default_nettype none
module psc_tagarr #(
    parameter int LINES = 512,
    parameter int IW    = 9,
    parameter int TW    = 21
) (
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    input  wire logic [IW-1:0] rd_idx,
    output logic      [TW-1:0] rd_tag,
    input  wire logic          wr_en,
    input  wire logic [IW-1:0] wr_idx,
    input  wire logic [TW-1:0] wr_tag
);
    logic [TW-1:0] mem [LINES];
    logic [TW-1:0] next_rd_tag;
    logic [TW-1:0] next_mem [LINES];

    // Next value of every tag and of the registered read.
    always_comb
    begin
        next_rd_tag = mem[rd_idx];
        for (int i = 0; i < LINES; i++)
        begin
            next_mem[i] = (wr_en && wr_idx == IW'(i)) ? wr_tag : mem[i];
        end
    end

    // Each entry is its own register so reset leaves every line invalid.
    genvar g;
    generate
        for (g = 0; g < LINES; g++)
        begin : g_line
            always_ff @(posedge sys_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    mem[g] <= '0;
                end
                else
                begin
                    mem[g] <= next_mem[g];
                end
            end
        end
    endgenerate

    // Registered read port.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_tag <= '0;
        end
        else
        begin
            rd_tag <= next_rd_tag;
        end
    end
endmodule // psc_tagarr
`default_nettype wire
